// ---- shared/smd_pkg.sv ----
package smd_pkg;

  // Register offsets on the plain register port
  localparam logic [3:0] SMD_ADDR_CLK_CTRL  = 4'h0;
  localparam logic [3:0] SMD_ADDR_CLK_SEL   = 4'h1;
  localparam logic [3:0] SMD_ADDR_OSC_DET   = 4'h2;
  localparam logic [3:0] SMD_ADDR_PROTECT   = 4'h3;
  localparam logic [3:0] SMD_ADDR_SW_FLAGS  = 4'h4;
  localparam logic [3:0] SMD_ADDR_WAKE_EN   = 4'h5;
  localparam logic [3:0] SMD_ADDR_STATUS    = 4'h6;

  // Clock control register fields
  localparam int SMD_B_ALL_STOP   = 0;
  localparam int SMD_B_DIV8       = 1;
  localparam int SMD_B_DIV_LO     = 2;
  localparam int SMD_B_DIV_HI     = 3;
  localparam int SMD_B_XTAL_STOP  = 4;
  localparam int SMD_B_LSOSC_STOP = 5;
  localparam int SMD_B_WAIT_REQ   = 6;
  localparam int SMD_B_PCLK_WAIT  = 7;

  // Clock select register fields
  localparam int SMD_B_WAKE_SEL   = 0;
  localparam int SMD_B_SRC_XTAL   = 1;
  localparam int SMD_B_LOWPWR     = 2;

  // Oscillation-stop-detect register fields
  localparam int SMD_B_DET_LO     = 0;
  localparam int SMD_B_DET_HI     = 1;
  localparam int SMD_B_OCO_SEL    = 2;
  localparam int SMD_B_XTAL_DEAD  = 3;

  // Protect register field
  localparam int SMD_B_CLK_WE     = 0;

  // Software flag register fields
  localparam int SMD_B_FL_REWRITE = 0;
  localparam int SMD_B_FL_LOWCUR  = 1;
  localparam int SMD_B_VMON_FDIS  = 2;

  // Wake source indices
  localparam int SMD_W_KEY        = 0;
  localparam int SMD_W_EXTPIN     = 1;
  localparam int SMD_W_TIMER      = 2;
  localparam int SMD_W_SERIAL     = 3;
  localparam int SMD_W_VMON1      = 4;
  localparam int SMD_NWAKE        = 5;

  // Reset values
  localparam logic [7:0] SMD_RST_CLK_CTRL = 8'h28;
  localparam logic [7:0] SMD_RST_CLK_SEL  = 8'h02;
  localparam logic [7:0] SMD_RST_OSC_DET  = 8'h04;
  localparam logic [7:0] SMD_RST_ZERO     = 8'h00;

  // Crystal loss detection: no edge within this time means stopped
  localparam int SMD_XTAL_TIMEOUT_NS = 1000;
  localparam int SMD_CLK_PERIOD_NS   = 5;
  localparam int SMD_XTAL_TIMEOUT_CYC =
    SMD_XTAL_TIMEOUT_NS / SMD_CLK_PERIOD_NS;
  localparam int SMD_PREFETCH_BYTES  = 4;

  // Power state machine
  typedef enum logic [1:0] {
    SMD_RUN  = 2'b00,
    SMD_STOP = 2'b01,
    SMD_WAKE = 2'b10,
    SMD_WAIT = 2'b11
  } smd_state_e;

endpackage

// ---- rtl/smd_stop_ctrl.sv ----
// Function
// - Stop mode gates off every oscillator except the watchdog low-speed one; here oco_en_o is cleared in stop as well.
// - Externally clocked peripherals keep running while internal clocks stop.
// - Key, unfiltered pin and unfiltered event-count timer interrupts wake.
// - External-clock serial and unfiltered voltage monitor 1 also wake.
// - Writing all-clocks-stop enters stop and forces divide-by-8 select.
// - Ports hold their state while stopped; crystal output pin driven high.
// - Only reset or a peripheral interrupt ends stop mode.
// - Interrupt sequence runs after request and restarted CPU clock.
// - CPU clock after wake is the previous source divided by 8.
// - Crystal loss with detect 11b selects on-chip osc, flags, interrupts.
// - Detection interrupt shares one vector with watchdog and vmon.
// - Crystal-stopped flag reports a stop only, not stability.
// - Prefetch takes four bytes past the stop request before halting; here wake waits for three fetch_done_i pulses in stop.
// - Clock register writes take effect only with protect bit 0 set.
//
// The address map and strobed register access are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module smd_stop_ctrl
  import smd_pkg::*;
(
  input  wire logic             ref_clk_i,
  input  wire logic             resetn_i,
  input  wire logic             clk_en_i,
  input  wire logic [3:0]       addr_i,
  input  wire logic [7:0]       wdata_i,
  input  wire logic             wr_i,
  input  wire logic             rd_i,
  output logic      [7:0]       rdata_o,
  input  wire logic [SMD_NWAKE-1:0] wake_req_i,
  input  wire logic             ext_filter_on_i,
  input  wire logic             timer_filter_on_i,
  input  wire logic             timer_event_mode_i,
  input  wire logic             serial_ext_clk_i,
  input  wire logic             crystal_input_clock_i,
  input  wire logic             fetch_done_i,
  output logic                  cpu_clk_en_o,
  output logic                  periph_clk_en_o,
  output logic                  xtal_en_o,
  output logic                  oco_en_o,
  output logic                  port_hold_o,
  output logic                  crystal_output_pin_o,
  output logic                  crystal_output_pin_oe_o,
  output logic                  wake_irq_o,
  output logic                  osc_det_irq_o,
  output logic                  shared_nmi_o,
  output logic [1:0]            sysclk_div_o,
  output logic                  sysclk_div8_select_o
);

  smd_state_e state_r;
  smd_state_e state_nxt;
  logic [7:0] clk_ctrl_r;
  logic [7:0] clk_sel_r;
  logic [7:0] osc_det_r;
  logic [7:0] protect_r;
  logic [7:0] sw_flags_r;
  logic [SMD_NWAKE-1:0] wake_en_r;
  logic [SMD_NWAKE-1:0] wake_s1_r;
  logic [SMD_NWAKE-1:0] wake_s2_r;
  logic [2:0] xin_sync_r;
  logic [15:0] xin_cnt_r;
  logic [1:0] pf_cnt_r;
  logic       det_irq_r;
  logic [7:0] rdata_r;

  // Register write decode; only the clock registers are qualified by protect bit
  function automatic logic is_wr(input logic [3:0] a,
                                 input logic [3:0] want,
                                 input logic       w);
    is_wr = w && (a == want);
  endfunction

  wire clk_we      = protect_r[SMD_B_CLK_WE];
  wire wr_ctrl     = is_wr(addr_i, SMD_ADDR_CLK_CTRL, wr_i) && clk_we;
  wire wr_sel      = is_wr(addr_i, SMD_ADDR_CLK_SEL, wr_i) && clk_we;
  wire wr_det      = is_wr(addr_i, SMD_ADDR_OSC_DET, wr_i) && clk_we;
  wire wr_prot     = is_wr(addr_i, SMD_ADDR_PROTECT, wr_i);
  wire wr_flags    = is_wr(addr_i, SMD_ADDR_SW_FLAGS, wr_i);
  wire wr_wake     = is_wr(addr_i, SMD_ADDR_WAKE_EN, wr_i);

  // Stop and wait requests from control writes
  wire stop_req    = wr_ctrl && wdata_i[SMD_B_ALL_STOP];
  wire wait_req    = wr_ctrl && wdata_i[SMD_B_WAIT_REQ];

  // Qualify wake sources by their usable conditions in stop
  logic [SMD_NWAKE-1:0] wake_ok;
  assign wake_ok[SMD_W_KEY]    = 1'b1;
  assign wake_ok[SMD_W_EXTPIN] = !ext_filter_on_i;
  assign wake_ok[SMD_W_TIMER]  = timer_event_mode_i &&
                                 !timer_filter_on_i;
  assign wake_ok[SMD_W_SERIAL] = serial_ext_clk_i;
  assign wake_ok[SMD_W_VMON1]  = sw_flags_r[SMD_B_VMON_FDIS];

  // Wake only from enabled, usable, synchronised requests
  wire wake_hit = |(wake_s2_r & wake_en_r & wake_ok);

  // Crystal loss: detection armed, crystal in use, edges absent
  wire det_armed = osc_det_r[SMD_B_DET_HI] &&
                   osc_det_r[SMD_B_DET_LO] &&
                   clk_sel_r[SMD_B_SRC_XTAL] &&
                   !osc_det_r[SMD_B_OCO_SEL];
  wire xin_edge  = xin_sync_r[2] ^ xin_sync_r[1];
  wire xin_lost  = det_armed &&
                   (xin_cnt_r == 16'(SMD_XTAL_TIMEOUT_CYC));

  // Next state of the power controller
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      SMD_RUN: begin
        if (stop_req) begin
          state_nxt = SMD_STOP;
        end else if (wait_req) begin
          state_nxt = SMD_WAIT;
        end
      end
      SMD_STOP: begin
        if (pf_cnt_r == 2'd3 && wake_hit) begin
          state_nxt = SMD_WAKE;
        end
      end
      SMD_WAKE: state_nxt = SMD_RUN;
      SMD_WAIT: begin
        if (wake_hit) begin
          state_nxt = SMD_RUN;
        end
      end
    endcase
  end

  // Wake request capture: two-stage sync of pin-side requests
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wake_s1_r <= '0;
      wake_s2_r <= '0;
      xin_sync_r <= '0;
    end else begin
      wake_s1_r <= wake_req_i;
      wake_s2_r <= wake_s1_r;
      xin_sync_r <= {xin_sync_r[1:0], crystal_input_clock_i};
    end
  end

  // State, prefetch count and crystal watchdog counter
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_r   <= SMD_RUN;
      pf_cnt_r  <= 2'd0;
      xin_cnt_r <= 16'h0000;
    end else if (clk_en_i) begin
      state_r <= state_nxt;
      if (state_r != SMD_STOP) begin
        pf_cnt_r <= 2'd0;
      end else if (pf_cnt_r != 2'd3 && fetch_done_i) begin
        pf_cnt_r <= pf_cnt_r + 2'd1;
      end
      if (!det_armed || xin_edge) begin
        xin_cnt_r <= 16'h0000;
      end else if (!xin_lost) begin
        xin_cnt_r <= xin_cnt_r + 16'h0001;
      end
    end
  end

  // Control registers with hardware-forced fields
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      clk_ctrl_r <= SMD_RST_CLK_CTRL;
      clk_sel_r  <= SMD_RST_CLK_SEL;
      protect_r  <= SMD_RST_ZERO;
      sw_flags_r <= SMD_RST_ZERO;
      wake_en_r  <= '0;
    end else if (clk_en_i) begin
      if (wr_ctrl) begin
        clk_ctrl_r <= wdata_i;
      end
      if (stop_req) begin
        clk_ctrl_r[SMD_B_DIV8] <= 1'b1;
      end
      if (state_r != SMD_RUN && state_nxt == SMD_RUN) begin
        clk_ctrl_r[SMD_B_ALL_STOP] <= 1'b0;
        clk_ctrl_r[SMD_B_WAIT_REQ] <= 1'b0;
      end
      if (xin_lost) begin
        clk_ctrl_r[SMD_B_LSOSC_STOP] <= 1'b0;
      end
      if (wr_sel) begin
        clk_sel_r <= wdata_i & 8'h07;
      end
      if (wr_prot) begin
        protect_r <= wdata_i & 8'h0F;
      end
      if (wr_flags) begin
        sw_flags_r <= wdata_i & 8'h07;
      end
      if (wr_wake) begin
        wake_en_r <= wdata_i[SMD_NWAKE-1:0];
      end
    end
  end

  // Detection register; hardware set wins over software write
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      osc_det_r <= SMD_RST_OSC_DET;
      det_irq_r <= 1'b0;
    end else if (clk_en_i) begin
      det_irq_r <= xin_lost;
      if (wr_det) begin
        osc_det_r <= wdata_i & 8'h0F;
      end
      if (xin_lost) begin
        osc_det_r[SMD_B_OCO_SEL]   <= 1'b1;
        osc_det_r[SMD_B_XTAL_DEAD] <= 1'b1;
      end
    end
  end

  // Read mux, data in the cycle after the strobe
  logic [7:0] rd_mux;
  assign rd_mux =
    (addr_i == SMD_ADDR_CLK_CTRL) ? clk_ctrl_r :
    (addr_i == SMD_ADDR_CLK_SEL)  ? clk_sel_r  :
    (addr_i == SMD_ADDR_OSC_DET)  ? osc_det_r  :
    (addr_i == SMD_ADDR_PROTECT)  ? protect_r  :
    (addr_i == SMD_ADDR_SW_FLAGS) ? sw_flags_r :
    (addr_i == SMD_ADDR_WAKE_EN)  ? {3'b000, wake_en_r} :
    (addr_i == SMD_ADDR_STATUS)   ? {6'h00, state_r} : 8'h00;

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_r <= 8'h00;
    end else if (clk_en_i) begin
      rdata_r <= rd_i ? rd_mux : 8'h00;
    end
  end

  // Clock gating and pin control, all registered
  wire stop_n = (state_nxt != SMD_STOP);
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cpu_clk_en_o            <= 1'b1;
      periph_clk_en_o         <= 1'b1;
      xtal_en_o               <= 1'b1;
      oco_en_o                <= 1'b0;
      port_hold_o             <= 1'b0;
      crystal_output_pin_o    <= 1'b0;
      crystal_output_pin_oe_o <= 1'b0;
      wake_irq_o              <= 1'b0;
      osc_det_irq_o           <= 1'b0;
      shared_nmi_o            <= 1'b0;
      sysclk_div_o            <= 2'b00;
      sysclk_div8_select_o    <= 1'b0;
    end else if (clk_en_i) begin
      cpu_clk_en_o    <= stop_n && (state_nxt != SMD_WAIT);
      periph_clk_en_o <= stop_n &&
        !(state_nxt == SMD_WAIT && clk_ctrl_r[SMD_B_PCLK_WAIT]);
      xtal_en_o       <= stop_n && !clk_ctrl_r[SMD_B_XTAL_STOP];
      oco_en_o        <= stop_n &&
        (osc_det_r[SMD_B_OCO_SEL] || !clk_ctrl_r[SMD_B_LSOSC_STOP]);
      port_hold_o     <= !stop_n;
      crystal_output_pin_o    <= !stop_n;
      crystal_output_pin_oe_o <= !stop_n;
      wake_irq_o      <= (state_r == SMD_WAKE);
      osc_det_irq_o   <= det_irq_r;
      shared_nmi_o    <= det_irq_r;
      sysclk_div_o    <= {clk_ctrl_r[SMD_B_DIV_HI],
                          clk_ctrl_r[SMD_B_DIV_LO]};
      // The forced divide-by-8 shows together with the stop entry
      sysclk_div8_select_o <= clk_ctrl_r[SMD_B_DIV8] || stop_req;
    end
  end

  assign rdata_o = rdata_r;

endmodule // smd_stop_ctrl
`default_nettype wire

// ---- verif/smd_stop_ctrl_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
module smd_stop_ctrl_monitor
  import smd_pkg::*;
(
  input wire logic                 ref_clk_i,
  input wire logic                 resetn_i,
  input wire logic [SMD_NWAKE-1:0] wake_req_i,
  input wire logic                 cpu_clk_en_o,
  input wire logic                 periph_clk_en_o,
  input wire logic                 xtal_en_o,
  input wire logic                 port_hold_o,
  input wire logic                 crystal_output_pin_o,
  input wire logic                 crystal_output_pin_oe_o,
  input wire logic                 wake_irq_o,
  input wire logic                 osc_det_irq_o,
  input wire logic                 shared_nmi_o,
  input wire logic                 sysclk_div8_select_o
);
  // All checks run on the system clock and sleep during reset
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);

  // Stop state: internal clocks gated, pins held, divider forced
  property p_gate;
    crystal_output_pin_o |-> !(cpu_clk_en_o | periph_clk_en_o | xtal_en_o);
  endproperty
  a_gate: assert property (p_gate)
    else $error("clock enable left on in stop");
  property p_pins;
    crystal_output_pin_o |-> crystal_output_pin_oe_o && port_hold_o;
  endproperty
  a_pins: assert property (p_pins)
    else $error("pins not held in stop");
  property p_div8;
    $rose(crystal_output_pin_o) |-> sysclk_div8_select_o;
  endproperty
  a_div8: assert property (p_div8)
    else $error("divide-by-8 not forced at stop entry");
  // Stop ends only through a synchronized wake request
  property p_exit;
    $fell(crystal_output_pin_o) |-> ##[0:3] wake_irq_o;
  endproperty
  a_exit: assert property (p_exit)
    else $error("stop left without wake interrupt");
  property p_wdiv;
    wake_irq_o |-> sysclk_div8_select_o && cpu_clk_en_o;
  endproperty
  a_wdiv: assert property (p_wdiv)
    else $error("wake clock not running divided by 8");
  property p_sync;
    wake_irq_o |-> $past(|wake_req_i, 2);
  endproperty
  a_sync: assert property (p_sync)
    else $error("wake faster than the request synchronizer");
  // Crystal loss interrupt
  property p_nmi;
    osc_det_irq_o |-> shared_nmi_o;
  endproperty
  a_nmi: assert property (p_nmi)
    else $error("loss interrupt missing on shared vector");
  property p_pulse;
    osc_det_irq_o |=> !osc_det_irq_o [*4];
  endproperty
  a_pulse: assert property (p_pulse)
    else $error("loss interrupt repeated");

  c_stop: cover property ($rose(crystal_output_pin_o));
  c_wake: cover property (wake_irq_o);
  c_loss: cover property (osc_det_irq_o);
endmodule // smd_stop_ctrl_monitor
`default_nettype wire

// ---- verif/smd_stop_ctrl_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
module smd_stop_ctrl_bench
  import smd_pkg::*;
;
  logic                 ref_clk_i = 1'h0;
  logic                 resetn_i  = 1'h0;
  logic [3:0]           addr      = 4'h0;
  logic [7:0]           wdata     = 8'h00;
  logic                 wr = 1'h0, rd = 1'h0, fdone = 1'h0;
  logic                 crystal_input_clock = 1'h0, xrun = 1'h1;
  logic [SMD_NWAKE-1:0] wreq = 5'h00;
  logic                 extf = 1'h0, tmf = 1'h0, tmev = 1'h1, sext = 1'h1;
  logic [7:0]           rdata;
  logic                 cpu_en, per_en, xt_en, hold, crystal_output_pin, crystal_output_pin_oe;
  logic                 wirq, dirq, nmi, div8, oco;
  logic [1:0]           divs;
  int                   miscompares = 0;
  int                   n_checks = 0;

  // System clock and a free crystal toggling at half its rate
  always #2.5 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i) if (xrun) crystal_input_clock <= ~crystal_input_clock;

  smd_stop_ctrl dut (
    .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .clk_en_i(1'h1),
    .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
    .wake_req_i(wreq), .ext_filter_on_i(extf), .timer_filter_on_i(tmf),
    .timer_event_mode_i(tmev), .serial_ext_clk_i(sext),
    .crystal_input_clock_i(crystal_input_clock), .fetch_done_i(fdone),
    .cpu_clk_en_o(cpu_en), .periph_clk_en_o(per_en), .xtal_en_o(xt_en),
    .oco_en_o(oco), .port_hold_o(hold), .crystal_output_pin_o(crystal_output_pin),
    .crystal_output_pin_oe_o(crystal_output_pin_oe), .wake_irq_o(wirq),
    .osc_det_irq_o(dirq), .shared_nmi_o(nmi), .sysclk_div_o(divs),
    .sysclk_div8_select_o(div8));

  task automatic check(input logic [7:0] got, input logic [7:0] exp,
                       input string msg);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  // Register port: one-cycle strobes launched after an edge
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    addr <= a;
    wdata <= d;
    wr <= 1'h1;
    @(posedge ref_clk_i);
    wr <= 1'h0;
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp,
                        input string msg);
    @(posedge ref_clk_i);
    addr <= a;
    rd <= 1'h1;
    @(posedge ref_clk_i);
    rd <= 1'h0;
    #1;
    check(rdata, exp, msg);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask

  // Put one wake source's qualifier in its usable or unusable state
  task automatic qual(input int i, input logic ok);
    case (i)
      SMD_W_EXTPIN: extf <= !ok;
      SMD_W_TIMER:  tmf <= !ok;
      SMD_W_SERIAL: sext <= ok;
      SMD_W_VMON1:  wr_reg(SMD_ADDR_SW_FLAGS, ok ? 8'h04 : 8'h00);
      default: ;
    endcase
  endtask

  // Enter stop, try a blocked wake unless i is the key source, then wake through source i
  task automatic stop_wake(input int i);
    int k;
    wr_reg(SMD_ADDR_CLK_CTRL, 8'h01);
    tick(2);
    check({cpu_en, per_en, xt_en, hold, crystal_output_pin, crystal_output_pin_oe, div8, 1'h0},
          8'h1E, "stop outputs");
    rd_chk(SMD_ADDR_STATUS, {6'h00, SMD_STOP}, "stop state");
    repeat (4) begin
      @(posedge ref_clk_i);
      fdone <= 1'h1;
      @(posedge ref_clk_i);
      fdone <= 1'h0;
    end
    if (i != SMD_W_KEY) begin
      qual(i, 1'h0);
      @(posedge ref_clk_i);
      wreq[i] <= 1'h1;
      tick(12);
      check({7'h00, crystal_output_pin}, 8'h01, "unusable source woke");
      qual(i, 1'h1);
    end else begin
      @(posedge ref_clk_i);
      wreq[i] <= 1'h1;
    end
    k = 0;
    while (wirq !== 1'h1 && k < 50) begin
      tick(1);
      k++;
    end
    check({6'h00, wirq, crystal_output_pin}, 8'h02, "no wake");
    check({6'h00, cpu_en, div8}, 8'h03, "wake clock");
    @(posedge ref_clk_i);
    wreq <= 5'h00;
    tick(4);
  endtask

  task automatic results;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Watchdog: the full sequence needs under a thousand cycles
  initial begin
    #100000;
    miscompares++;
    results();
  end

  // Main sequence
  initial begin
    repeat (3) @(posedge ref_clk_i);
    resetn_i <= 1'h1;
    rd_chk(SMD_ADDR_CLK_CTRL, SMD_RST_CLK_CTRL, "ctrl reset");
    rd_chk(SMD_ADDR_CLK_SEL, SMD_RST_CLK_SEL, "select reset");
    rd_chk(SMD_ADDR_OSC_DET, SMD_RST_OSC_DET, "detect reset");
    rd_chk(SMD_ADDR_STATUS, 8'h00, "state reset");
    rd_chk(4'hF, 8'h00, "unmapped read");
    wr_reg(4'hF, 8'hFF);
    wr_reg(SMD_ADDR_CLK_CTRL, 8'h01);
    tick(3);
    check({7'h00, crystal_output_pin}, 8'h00, "stop while locked");
    rd_chk(SMD_ADDR_CLK_CTRL, SMD_RST_CLK_CTRL, "locked write");
    wr_reg(SMD_ADDR_PROTECT, 8'h01);
    wr_reg(SMD_ADDR_WAKE_EN, 8'h1F);
    wr_reg(SMD_ADDR_SW_FLAGS, 8'h04);
    rd_chk(SMD_ADDR_PROTECT, 8'h01, "protect readback");
    for (int i = 0; i < SMD_NWAKE; i++) stop_wake(i);
    // Wait mode by control bit, peripheral clock kept, key wakes
    wr_reg(SMD_ADDR_CLK_CTRL, 8'h40);
    tick(2);
    check({6'h00, cpu_en, per_en}, 8'h01, "wait clocks");
    @(posedge ref_clk_i);
    wreq[SMD_W_KEY] <= 1'h1;
    tick(6);
    check({6'h00, cpu_en, per_en}, 8'h03, "wait exit");
    rd_chk(SMD_ADDR_CLK_CTRL, 8'h00, "wait bit cleared");
    @(posedge ref_clk_i);
    wreq <= 5'h00;
    tick(4);
    // Crystal loss with detection armed
    wr_reg(SMD_ADDR_CLK_CTRL, 8'h20);
    wr_reg(SMD_ADDR_OSC_DET, 8'h03);
    tick(300);
    check({5'h00, oco, divs}, 8'h00, "osc off before loss");
    xrun <= 1'h0;
    for (int k = 0; k < 400 && dirq !== 1'h1; k++) tick(1);
    check({6'h00, dirq, nmi}, 8'h03, "loss interrupt");
    tick(2);
    check({5'h00, oco, divs}, 8'h04, "fallback osc on");
    rd_chk(SMD_ADDR_OSC_DET, 8'h0F, "loss flags");
    rd_chk(SMD_ADDR_CLK_CTRL, 8'h00, "low-speed osc restart");
    xrun <= 1'h1;
    tick(50);
    rd_chk(SMD_ADDR_OSC_DET, 8'h0F, "no automatic switch back");
    results();
  end
endmodule // smd_stop_ctrl_bench

bind smd_stop_ctrl smd_stop_ctrl_monitor u_mon (
  .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .wake_req_i(wake_req_i),
  .cpu_clk_en_o(cpu_clk_en_o), .periph_clk_en_o(periph_clk_en_o),
  .xtal_en_o(xtal_en_o), .port_hold_o(port_hold_o),
  .crystal_output_pin_o(crystal_output_pin_o),
  .crystal_output_pin_oe_o(crystal_output_pin_oe_o),
  .wake_irq_o(wake_irq_o), .osc_det_irq_o(osc_det_irq_o),
  .shared_nmi_o(shared_nmi_o), .sysclk_div8_select_o(sysclk_div8_select_o));
`default_nettype wire
